// ===== riag_gate.sv
// lock/key gate and indirect address control in front of the clock's internal registers
`timescale 1ns/1ps
`include "riag_cfg.svh"
module riag_gate (
	input wire logic CLK,
	input wire logic RST_N,
	input riag_pkg::riag_sfr_req_t SFR_REQ,
	output logic [7:0] SFR_RDATA,
	output riag_pkg::riag_int_req_t INT_REQ,
	input wire logic [7:0] INT_RDATA,
	output logic [7:0] DATA_Q
);
	import riag_pkg::*;

	riag_lock_t lock_q;
	logic key_first_ok;
	logic key_second_ok;

	logic busy_q;
	logic auto_q;
	logic fast_q;
	logic [3:0] index_q;
	logic [2:0] cnt_q;
	logic xfer_rd_q;
	logic [7:0] data_q;

	logic unlocked;
	logic key_wr;
	logic adr_wr;
	logic dat_wr;
	logic dat_rd;
	logic cfg_take;
	logic index_take;
	logic busy_kick;
	logic auto_kick;
	logic access_try;

	logic start_rd;
	logic start_wr;
	logic start_any;
	logic fast_now;
	logic done;
	logic strobe_rd;
	logic strobe_wr;
	logic [7:0] lock_code;
	logic [7:0] adr_image;

	// register select of the processor bus; reads and writes share the decode
	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		reg_hit = addr == offset;
	endfunction

	// capture bytes sit at the bottom of the internal map
	function automatic logic in_snapshot(input logic [3:0] idx);
		in_snapshot = idx <= `RIAG_SNAP_LAST;
	endfunction

	function automatic logic in_wake(input logic [3:0] idx);
		in_wake = (idx >= `RIAG_WAKE_FIRST) && (idx <= `RIAG_WAKE_LAST);
	endfunction

	// capture and compare bytes step the index so four-byte values stream
	function automatic logic auto_inc(input logic [3:0] idx);
		auto_inc = in_snapshot(idx) || in_wake(idx);
	endfunction

	// the index wraps within four bits, as the select field has no carry out
	function automatic logic [3:0] idx_step(input logic [3:0] idx);
		logic [4:0] wide;
		wide = {1'b0, idx} + 5'h01;
		idx_step = wide[3:0];
	endfunction

	// the normal strobe is the reset choice; the short one saves a cycle per byte
	function automatic logic [2:0] strobe_cycles(input logic fast);
		logic [2:0] n;
		if (fast) begin
			n = `RIAG_CYC_FAST;
		end else begin
			n = `RIAG_CYC_NORMAL;
		end
		strobe_cycles = n;
	endfunction

	function automatic logic [7:0] state_code(input riag_lock_t st);
		logic [7:0] code;
		case (st)
			RIAG_LOCKED: begin
				code = `RIAG_ST_LOCKED;
			end
			RIAG_FIRST_KEY: begin
				code = `RIAG_ST_FIRST;
			end
			RIAG_UNLOCKED: begin
				code = `RIAG_ST_UNLOCKED;
			end
			default: begin
				code = `RIAG_ST_DISABLED;
			end
		endcase
		state_code = code;
	endfunction

	// bit 5 has no storage behind it, so it reads back as zero
	function automatic logic [7:0] adr_pack(
		input logic busy,
		input logic auto_rd,
		input logic fast,
		input logic [3:0] idx
	);
		logic [7:0] v;
		v = 8'h00;
		v[`RIAG_BUSY_BIT] = busy;
		v[`RIAG_AUTO_READ_ENABLE_BIT] = auto_rd;
		v[`RIAG_UNUSED_BIT] = 1'b0;
		v[`RIAG_FAST_BIT] = fast;
		v[3:0] = idx;
		adr_pack = v;
	endfunction

	assign unlocked = lock_q == RIAG_UNLOCKED;
	assign key_wr = SFR_REQ.wr && reg_hit(SFR_REQ.addr, `RIAG_KEY_OFFSET);
	assign adr_wr = SFR_REQ.wr && reg_hit(SFR_REQ.addr, `RIAG_ADR_OFFSET);
	assign dat_wr = SFR_REQ.wr && reg_hit(SFR_REQ.addr, `RIAG_DAT_OFFSET);
	assign dat_rd = SFR_REQ.rd && reg_hit(SFR_REQ.addr, `RIAG_DAT_OFFSET);
	assign key_first_ok = key_wr && (SFR_REQ.wdata == `RIAG_KEY_FIRST);
	assign key_second_ok = key_wr && (SFR_REQ.wdata == `RIAG_KEY_SECOND);
	assign busy_kick = adr_wr && SFR_REQ.wdata[`RIAG_BUSY_BIT];
	assign auto_kick = dat_rd && auto_q;

	// address writes are taken only while unlocked; the select also waits for idle
	assign cfg_take = adr_wr && unlocked;
	assign index_take = cfg_take && !busy_q;

	// a locked-side access counts only as an indirect transfer attempt
	assign access_try = busy_kick || dat_wr || auto_kick;

	// new transfers are refused while one is running; software polls busy
	assign start_rd = unlocked && !busy_q && (busy_kick || auto_kick);
	assign start_wr = unlocked && !busy_q && dat_wr;
	assign start_any = start_rd || start_wr;

	// the strobe length written together with a start applies to that transfer
	assign fast_now = adr_wr ? SFR_REQ.wdata[`RIAG_FAST_BIT] : fast_q;
	assign done = busy_q && (cnt_q == 3'h1);
	assign strobe_rd = done && xfer_rd_q;
	assign strobe_wr = done && !xfer_rd_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_q <= RIAG_LOCKED;
		end else begin
			case (lock_q)
				RIAG_LOCKED: begin
					if (key_first_ok) begin
						lock_q <= RIAG_FIRST_KEY;
					end else if (key_wr || access_try) begin
						lock_q <= RIAG_DISABLED;
					end
				end
				RIAG_FIRST_KEY: begin
					if (key_second_ok) begin
						lock_q <= RIAG_UNLOCKED;
					end else if (key_wr || access_try) begin
						lock_q <= RIAG_DISABLED;
					end
				end
				RIAG_UNLOCKED: begin
					if (key_wr) begin
						lock_q <= RIAG_LOCKED;
					end
				end
				RIAG_DISABLED: begin
					lock_q <= RIAG_DISABLED;
				end
				default: begin
					lock_q <= RIAG_DISABLED;
				end
			endcase
		end
	end

	// the mode bits change only on an address write taken while unlocked
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			auto_q <= 1'b0;
		end else if (cfg_take) begin
			auto_q <= SFR_REQ.wdata[`RIAG_AUTO_READ_ENABLE_BIT];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fast_q <= 1'b0;
		end else if (cfg_take) begin
			fast_q <= SFR_REQ.wdata[`RIAG_FAST_BIT];
		end
	end

	// index write on the same cycle as a read start selects the target first
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			index_q <= 4'h0;
		end else if (index_take) begin
			index_q <= SFR_REQ.wdata[3:0];
		end else if (done && auto_inc(index_q)) begin
			index_q <= idx_step(index_q);
		end
	end

	// busy covers every cycle of the transfer, the strobe cycle included
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_q <= 1'b0;
		end else if (start_any) begin
			busy_q <= 1'b1;
		end else if (done) begin
			busy_q <= 1'b0;
		end
	end

	// counter runs down to zero; the strobe fires on the cycle at which it holds one
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_q <= 3'h0;
		end else if (start_any) begin
			cnt_q <= strobe_cycles(fast_now);
		end else if (busy_q) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	// direction is latched at the start so a later bus cycle cannot flip it
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			xfer_rd_q <= 1'b0;
		end else if (start_any) begin
			xfer_rd_q <= start_rd;
		end
	end

	// write data stays visible until the next transfer replaces it
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			data_q <= 8'h00;
		end else if (start_wr) begin
			data_q <= SFR_REQ.wdata;
		end else if (strobe_rd) begin
			data_q <= INT_RDATA;
		end
	end

	// internal strobe on the last transfer cycle, when the index is still the target
	always_comb begin
		INT_REQ = '0;
		INT_REQ.wr = strobe_wr;
		INT_REQ.rd = strobe_rd;
		INT_REQ.addr = index_q;
		INT_REQ.wdata = data_q;
	end

	always_comb begin
		lock_code = state_code(lock_q);
	end

	always_comb begin
		adr_image = adr_pack(busy_q, auto_q, fast_q, index_q);
	end

	// key reads have no side effect, so key polling never disturbs the sequence; a data read with autoread set starts a read while unlocked and idle
	always_comb begin
		case (SFR_REQ.addr)
			`RIAG_KEY_OFFSET: begin
				SFR_RDATA = lock_code;
			end
			`RIAG_ADR_OFFSET: begin
				SFR_RDATA = adr_image;
			end
			`RIAG_DAT_OFFSET: begin
				SFR_RDATA = data_q;
			end
			default: begin
				SFR_RDATA = 8'h00;
			end
		endcase
	end

	assign DATA_Q = data_q;
endmodule

// ===== riag_cfg.svh
// offsets, field positions, reset values and timing counts of the indirect access gate
`ifndef RIAG_CFG_SVH
`define RIAG_CFG_SVH
`define RIAG_ADR_OFFSET 8'hAC
`define RIAG_DAT_OFFSET 8'hAD
`define RIAG_KEY_OFFSET 8'hAE
`define RIAG_ADR_RESET 8'h00
`define RIAG_BUSY_BIT 7
`define RIAG_AUTO_READ_ENABLE_BIT 6
`define RIAG_UNUSED_BIT 5
`define RIAG_FAST_BIT 4
`define RIAG_KEY_FIRST 8'hA5
`define RIAG_KEY_SECOND 8'hF1
`define RIAG_ST_LOCKED 8'h00
`define RIAG_ST_FIRST 8'h01
`define RIAG_ST_UNLOCKED 8'h02
`define RIAG_ST_DISABLED 8'h03
`define RIAG_CYC_NORMAL 3'h7
`define RIAG_CYC_FAST 3'h6
`define RIAG_SNAP_LAST 4'h3
`define RIAG_WAKE_FIRST 4'h8
`define RIAG_WAKE_LAST 4'hB
`endif

// ===== riag_pkg.sv
// types of the indirect access gate
package riag_pkg;
	typedef enum logic [1:0] {
		RIAG_LOCKED,
		RIAG_FIRST_KEY,
		RIAG_UNLOCKED,
		RIAG_DISABLED
	} riag_lock_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} riag_sfr_req_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} riag_int_req_t;
endpackage

// ===== riag_gate_assertions.sv
// port checker of the indirect access gate
`timescale 1ns/1ps
module riag_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input riag_pkg::riag_sfr_req_t SFR_REQ,
	input wire logic [7:0] SFR_RDATA,
	input riag_pkg::riag_int_req_t INT_REQ,
	input wire logic [7:0] INT_RDATA,
	input wire logic [7:0] DATA_Q
);
	import riag_pkg::*;
	wire ac = SFR_REQ.addr == 8'hAC;
	wire ad = SFR_REQ.addr == 8'hAD;
	wire ae = SFR_REQ.addr == 8'hAE;
	wire go_w = SFR_REQ.wr && ad;
	// an autoread kick is counted even when disabled: the check only bounds timing
	wire go_r = SFR_REQ.wr && ac && SFR_REQ.wdata[7] || SFR_REQ.rd && ad;
	wire dq_src = INT_REQ.rd || go_w;
	wire strb = INT_REQ.rd || INT_REQ.wr;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_one; strb |=> !strb; endproperty
	a_one: assert property (p_one) else $error("long strobe");
	property p_rd; INT_REQ.rd |=> DATA_Q == $past(INT_RDATA); endproperty
	a_rd: assert property (p_rd) else $error("read data lost");
	// the strobe comes six cycles after the request with the short strobe, else seven
	property p_rgo; INT_REQ.rd |-> $past(go_r, 6) || $past(go_r, 7); endproperty
	a_rgo: assert property (p_rgo) else $error("read timing");
	property p_wgo; INT_REQ.wr |-> $past(go_w, 6) || $past(go_w, 7); endproperty
	a_wgo: assert property (p_wgo) else $error("write timing");
	property p_dq; !$stable(DATA_Q) |-> $past(dq_src); endproperty
	a_dq: assert property (p_dq) else $error("data changed");
	property p_unu; ac |-> !SFR_RDATA[5]; endproperty
	a_unu: assert property (p_unu) else $error("bit 5 set");
	property p_key; ae |-> SFR_RDATA[7:2] == 6'h00; endproperty
	a_key: assert property (p_key) else $error("key code");
	sequence s_dis_seen; ae && SFR_RDATA == 8'h03 ##1 ae; endsequence
	property p_dis; s_dis_seen |-> SFR_RDATA == 8'h03; endproperty
	a_dis: assert property (p_dis) else $error("left disabled");
endmodule
bind riag_gate riag_chk chk_u (.CLK(CLK), .RST_N(RST_N), .SFR_REQ(SFR_REQ),
	.SFR_RDATA(SFR_RDATA), .INT_REQ(INT_REQ), .INT_RDATA(INT_RDATA), .DATA_Q(DATA_Q));

// ===== riag_far_model.sv
// internal clock register file answering the gate's strobes
`timescale 1ns/1ps
module riag_regs (
	input wire logic CLK,
	input riag_pkg::riag_int_req_t INT_REQ,
	output logic [7:0] INT_RDATA
);
	import riag_pkg::*;
	logic [7:0] m_q [16];
	initial for (int i = 0; i < 16; i++) m_q[i] = 8'h40 + 8'(i);
	always @(posedge CLK) if (INT_REQ.wr) m_q[INT_REQ.addr] <= INT_REQ.wdata;
	// off-strobe the bus shows inverted data so a late sample is caught
	assign INT_RDATA = INT_REQ.rd ? m_q[INT_REQ.addr] : ~m_q[INT_REQ.addr];
endmodule

// ===== test_rtc_indirect_access_gate.sv
// register-level test of the indirect access gate
`timescale 1ns/1ps
module test_rtc_indirect_access_gate;
	import riag_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0;
	logic [7:0] rd_v, in_v, dq_v;
	riag_sfr_req_t req = '0;
	riag_int_req_t ir;
	int n_mismatch = 0, checked = 0;
	always #5 clk = ~clk;
	riag_gate dut_u (.CLK(clk), .RST_N(rst_n), .SFR_REQ(req), .SFR_RDATA(rd_v),
		.INT_REQ(ir), .INT_RDATA(in_v), .DATA_Q(dq_v));
	riag_regs far_u (.CLK(clk), .INT_REQ(ir), .INT_RDATA(in_v));
	task automatic tally_and_finish;
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// an idle edge follows each access so a strobe is never driven twice at once
	task automatic acc(input logic w, input logic [7:0] a, d, input int g = 0);
		req <= '{w, !w, a, d};
		// read data is combinational, so it is compared mid-cycle while the request stands
		@(negedge clk);
		if (!w) begin
			checked++;
			if (rd_v !== d) begin
				n_mismatch++;
				$display("wrong value at %0t: %h, expected %h", $time, rd_v, d);
			end
		end
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		repeat (g + 1) @(posedge clk);
	endtask
	task automatic dq_chk(input logic [7:0] d);
		@(negedge clk);
		checked++;
		if (dq_v !== d) begin
			n_mismatch++;
			$display("wrong value at %0t: %h, expected %h", $time, dq_v, d);
		end
		@(posedge clk);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		acc(0,8'hAE,8'h00);
		acc(1,8'hAE,8'hA5);
		acc(0,8'hAE,8'h01);
		acc(1,8'hAE,8'hF1);
		acc(0,8'hAE,8'h02);
		acc(1,8'hAC,8'hF8,8);
		acc(0,8'hAD,8'h48,8);
		acc(0,8'hAC,8'h5A);
		acc(1,8'hAD,8'h77,8);
		acc(1,8'hAC,8'h8A,8);
		acc(0,8'hAD,8'h77);
		acc(0,8'hAC,8'h0B);
		acc(1,8'hAC,8'h81);
		acc(0,8'hAC,8'h81,8);
		acc(0,8'hAC,8'h02);
		acc(0,8'hAD,8'h41);
		dq_chk(8'h41);
		acc(1,8'hAE,8'h00);
		acc(1,8'hAD,8'h00);
		acc(1,8'hAE,8'hA5);
		acc(0,8'hAE,8'h03);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		acc(1,8'hAE,8'hA5);
		acc(1,8'hAE,8'h12);
		acc(0,8'hAE,8'h03);
		tally_and_finish();
	end
	initial begin
		#5000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
